//--- rtl/mdp_pkg.sv
// Purpose: Shared constants and types for motor protection control
// Assumes: 25 MHz clock, level inputs already decoded from pins
// Notes:   Times kept in their own unit, cycle counts derived
package mdp_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 25000000;
   localparam int unsigned LOCK_SHORT_MS = 500;
   localparam int unsigned LOCK_LONG_MS  = 1000;
   localparam int unsigned LATCH_MS      = 2000;
   localparam int unsigned REL_SHORT_MS  = 5000;
   localparam int unsigned REL_LONG_MS   = 10000;
   localparam int unsigned IMM_REL_US    = 70;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned CYC_PER_US    = CLK_HZ / 1000000;
   localparam int unsigned LOCK_SHORT_CYC = LOCK_SHORT_MS * CYC_PER_MS;
   localparam int unsigned LOCK_LONG_CYC  = LOCK_LONG_MS * CYC_PER_MS;
   localparam int unsigned LATCH_CYC      = LATCH_MS * CYC_PER_MS;
   localparam int unsigned REL_SHORT_CYC  = REL_SHORT_MS * CYC_PER_MS;
   localparam int unsigned REL_LONG_CYC   = REL_LONG_MS * CYC_PER_MS;
   localparam int unsigned IMM_REL_CYC    = IMM_REL_US * CYC_PER_US;
   localparam int unsigned CNT_W          = 28;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] DIR_FWD = 2'h0;
   localparam logic [1:0] DIR_MID = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;

   typedef enum logic [1:0] {
      MDP_OUT_DRIVE,
      MDP_OUT_BRAKE,
      MDP_OUT_OFF
   } mdp_out_t;

   typedef struct packed {
      logic uv;
      logic ov;
      logic oc;
      logic therm;
   } mdp_flags_t;

   typedef struct packed {
      logic lock_mode;
      logic lock_timing;
      logic ov_sel;
   } mdp_cfg_t;

endpackage : mdp_pkg

//--- rtl/mdp_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second stage
module mdp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } mdp_sync_st_t;

   mdp_sync_st_t st_q;
   mdp_sync_st_t st_d;

   // Only the second stage leaves the module
   always_comb begin
      st_d      = st_q;
      st_d.meta = din;
      st_d.held = st_q.meta;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.held;
endmodule // mdp_sync

//--- rtl/mdp_ctrl.sv
// Purpose: Mode and protection control of a fan-motor driver
// Assumes: Comparators give hysteretic levels; Hall edge is a level
// Notes:   Counts are parameters so simulation can shorten them
module mdp_ctrl
   import mdp_pkg::*;
#(
   parameter int unsigned LOCK_SHORT = LOCK_SHORT_CYC,
   parameter int unsigned LOCK_LONG  = LOCK_LONG_CYC,
   parameter int unsigned LATCH_T    = LATCH_CYC,
   parameter int unsigned REL_SHORT  = REL_SHORT_CYC,
   parameter int unsigned REL_LONG   = REL_LONG_CYC,
   parameter int unsigned IMM_REL    = IMM_REL_CYC
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] direction_select,
   input  wire logic       sleep_in,
   input  wire logic       hall_cmp,
   input  wire logic       speed_command_input,
   input  wire mdp_flags_t flags_in,
   input  wire mdp_cfg_t   cfg_in,
   output mdp_out_t        motor_mode,
   output logic            reverse_dir,
   output logic            regulator_output_en,
   output logic            ov_high_thresh_sel,
   output logic            lock_flag_output_n
);

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   // Width follows the bundle so no pin bit is dropped
   localparam int unsigned SW = 5 + $bits(mdp_flags_t) + $bits(mdp_cfg_t);
   logic [SW-1:0] raw_s;
   logic [SW-1:0] syn_s;
   assign raw_s = {direction_select, sleep_in, hall_cmp, speed_command_input,
                   flags_in, cfg_in};

   mdp_sync #(.W(SW)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  (raw_s),
      .dout (syn_s)
   );

   logic [1:0] dir_s;
   logic       sleep_s;
   logic       hall_s;
   logic       speed_s;
   mdp_flags_t flg_s;
   mdp_cfg_t   cfg_s;
   assign {dir_s, sleep_s, hall_s, speed_s, flg_s, cfg_s} = syn_s;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LK_RUN,
      LK_LOCKED,
      LK_LATCHED
   } mdp_lk_t;

   typedef struct packed {
      mdp_lk_t          lk;
      logic [CNT_W-1:0] cnt;
      logic             hall_prev;
      logic             speed_prev;
      logic             uv_prev;
      mdp_out_t         mode;
      logic             rev;
      logic             reg_en;
      logic             flag_n;
   } mdp_st_t;

   mdp_st_t st_q;
   mdp_st_t st_d;

   function automatic logic [CNT_W-1:0] to_cnt(input int unsigned v);
      return v[CNT_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic hall_edge;
   logic speed_rise;
   logic uv_rise;
   logic [CNT_W-1:0] det_lim;
   logic [CNT_W-1:0] rel_lim;
   logic brake_req;

   always_comb begin
      st_d       = st_q;
      hall_edge  = hall_s ^ st_q.hall_prev;
      speed_rise = speed_s & ~st_q.speed_prev;
      uv_rise    = flg_s.uv & ~st_q.uv_prev;
      st_d.hall_prev  = hall_s;
      st_d.speed_prev = speed_s;
      st_d.uv_prev    = flg_s.uv;
      det_lim = cfg_s.lock_timing ? to_cnt(LOCK_LONG) : to_cnt(LOCK_SHORT);
      rel_lim = cfg_s.lock_timing ? to_cnt(REL_LONG) : to_cnt(REL_SHORT);
      if (cfg_s.lock_mode && !cfg_s.lock_timing) begin
         det_lim = to_cnt(LATCH_T);
      end
      if (cfg_s.lock_mode && cfg_s.lock_timing) begin
         // Immediate mode detects on the short time, not the long one
         det_lim = to_cnt(LOCK_SHORT);
         rel_lim = to_cnt(IMM_REL);
      end
      if (sleep_s) begin
         // Sleep clears the lock state and count; protections idle
         st_d.lk  = LK_RUN;
         st_d.cnt = '0;
      end else begin
         case (st_q.lk)
            LK_RUN: begin
               if (hall_edge) begin
                  st_d.cnt = '0;
               end else if (st_q.cnt + 1'b1 >= det_lim) begin
                  st_d.cnt = '0;
                  st_d.lk  = cfg_s.lock_mode && !cfg_s.lock_timing ?
                             LK_LATCHED : LK_LOCKED;
               end else begin
                  st_d.cnt = st_q.cnt + 1'b1;
               end
            end
            LK_LOCKED: begin
               if (hall_edge || speed_rise || uv_rise) begin
                  st_d.lk  = LK_RUN;
                  st_d.cnt = '0;
               end else if (st_q.cnt + 1'b1 >= rel_lim) begin
                  st_d.lk  = LK_RUN;
                  st_d.cnt = '0;
               end else begin
                  st_d.cnt = st_q.cnt + 1'b1;
               end
            end
            LK_LATCHED: begin
               // Only undervoltage or sleep frees a latch; Hall ignored
               if (uv_rise) begin
                  st_d.lk = LK_RUN;
               end
               st_d.cnt = '0;
            end
            default: begin
               st_d.lk  = LK_RUN;
               st_d.cnt = '0;
            end
         endcase
      end

      brake_req = (dir_s == DIR_MID) || (st_d.lk != LK_RUN)
                  || flg_s.uv || flg_s.ov || flg_s.oc;
      if (sleep_s || flg_s.therm) begin
         st_d.mode = MDP_OUT_OFF;
      end else if (brake_req) begin
         st_d.mode = MDP_OUT_BRAKE;
      end else begin
         st_d.mode = MDP_OUT_DRIVE;
      end
      st_d.rev    = (dir_s == DIR_REV);
      st_d.reg_en = ~sleep_s;
      st_d.flag_n = (st_d.lk == LK_RUN);
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= '{lk: LK_RUN, cnt: '0, hall_prev: 1'b0, speed_prev: 1'b0,
                   uv_prev: 1'b0, mode: MDP_OUT_OFF, rev: 1'b0,
                   reg_en: 1'b1, flag_n: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign motor_mode          = st_q.mode;
   assign reverse_dir         = st_q.rev;
   assign regulator_output_en = st_q.reg_en;
   assign ov_high_thresh_sel  = cfg_s.ov_sel;
   assign lock_flag_output_n  = st_q.flag_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sleep_off: assert property (@(posedge clk) disable iff (!rstn)
      sleep_s |=> motor_mode == MDP_OUT_OFF && !regulator_output_en)
      else $error("sleep did not turn outputs off");
   a_sleep_noprot: assert property (@(posedge clk) disable iff (!rstn)
      sleep_s |=> lock_flag_output_n)
      else $error("lock flag active in sleep");
   a_therm_off: assert property (@(posedge clk) disable iff (!rstn)
      flg_s.therm |=> motor_mode == MDP_OUT_OFF)
      else $error("thermal did not force off");
   a_mid_brake: assert property (@(posedge clk) disable iff (!rstn)
      dir_s == DIR_MID && !sleep_s && !flg_s.therm
      |=> motor_mode == MDP_OUT_BRAKE)
      else $error("middle direction not braking");
   a_prot_brake: assert property (@(posedge clk) disable iff (!rstn)
      (flg_s.uv || flg_s.ov || flg_s.oc) && !sleep_s && !flg_s.therm
      |=> motor_mode == MDP_OUT_BRAKE)
      else $error("voltage or current trip not braking");
   a_lock_brake: assert property (@(posedge clk) disable iff (!rstn)
      !lock_flag_output_n && !$past(sleep_s) && !$past(flg_s.therm)
      |-> motor_mode == MDP_OUT_BRAKE)
      else $error("lock flag without brake");
   a_latch_hold: assert property (@(posedge clk) disable iff (!rstn)
      st_q.lk == LK_LATCHED && !sleep_s && !uv_rise
      |=> st_q.lk == LK_LATCHED)
      else $error("latched lock released early");
   a_hall_rel: assert property (@(posedge clk) disable iff (!rstn)
      st_q.lk == LK_LOCKED && hall_edge |=> st_q.lk == LK_RUN)
      else $error("hall edge did not release lock");
   a_rev_dir: assert property (@(posedge clk) disable iff (!rstn)
      dir_s == DIR_REV |=> reverse_dir)
      else $error("reverse not reported");

endmodule // mdp_ctrl

//--- testbench/mdp_motor_model.sv
// Purpose: Fan motor with one Hall sensor on the Hall input
// Assumes: Rotor turns only while driven and not held
// Notes:   kick turns the rotor by hand, one Hall edge
module mdp_motor_model
   import mdp_pkg::*;
#(
   parameter int unsigned HALF = 8
) (
   input  wire logic     clk,
   input  wire logic     rstn,
   input  wire mdp_out_t motor_mode,
   input  wire logic     stall,
   input  wire logic     kick,
   output logic          hall_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt;

   // Brake and off stop the rotor, so only kick gives edges then
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt      <= 0;
         hall_cmp <= 1'b0;
      end else if (kick) begin
         hall_cmp <= ~hall_cmp;
      end else if (motor_mode == MDP_OUT_DRIVE && !stall) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) begin
            hall_cmp <= ~hall_cmp;
         end
      end
   end
endmodule // mdp_motor_model

//--- testbench/mdp_ctrl_tb.sv
// Purpose: Self-checking bench for motor protection control
// Assumes: Shortened lock counts, motor model on the Hall input
// Notes:   Expected levels queued, compared by a monitor
module mdp_ctrl_tb
   import mdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned LS = 50, LL = 100, LT = 200;
   localparam int unsigned RS = 500, RL = 1000, IR = 10;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [1:0] dir = DIR_FWD;
   logic       sleep = 1'b0, spd = 1'b0, stall = 1'b0, kick = 1'b0;
   mdp_flags_t flg = '0;
   mdp_cfg_t   cfg = '0;
   logic       hall, rev, reg_en, ovs, lock_n;
   mdp_out_t   mode;
   logic [5:0] exp_q[$];
   logic [31:0] seed = 32'h0001_7DF2;
   int         err_count = 0;
   int         n_compared = 0;
   event       chk;

   mdp_ctrl #(.LOCK_SHORT(LS), .LOCK_LONG(LL), .LATCH_T(LT),
      .REL_SHORT(RS), .REL_LONG(RL), .IMM_REL(IR)) dut_u (
      .clk(clk), .rstn(rstn), .direction_select(dir),
      .sleep_in(sleep), .hall_cmp(hall), .speed_command_input(spd),
      .flags_in(flg), .cfg_in(cfg), .motor_mode(mode),
      .reverse_dir(rev), .regulator_output_en(reg_en),
      .ov_high_thresh_sel(ovs), .lock_flag_output_n(lock_n));

   mdp_motor_model motor_u (.clk(clk), .rstn(rstn), .motor_mode(mode),
      .stall(stall), .kick(kick), .hall_cmp(hall));

   initial begin
      forever #20 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      end_of_test();
   end

   always @(chk) begin
      logic [5:0] e;
      e = exp_q.pop_front();
      n_compared++;
      if ({mode, rev, reg_en, lock_n, ovs} !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time,
                  {mode, rev, reg_en, lock_n, ovs}, e);
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic ck(input int n, input mdp_out_t m, input logic lk);
      cyc(n);
      exp_q.push_back({m, dir == DIR_REV, !sleep, lk, cfg.ov_sel});
      -> chk;
   endtask

   // Bounded wait for the lock flag to fall
   task automatic wait_lock(input int n);
      int i;
      for (i = 0; i < n && lock_n !== 1'b0; i++) begin
         cyc(1);
      end
      if (i == n) begin
         err_count++;
         end_of_test();
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      int l, r;
      cyc(2);
      rstn = 1'b1;
      ck(10, MDP_OUT_DRIVE, 1'b1);
      for (int d = 0; d < 4; d++) begin
         seed = xs(seed);
         dir = d[1:0];
         cfg.ov_sel = seed[0];
         ck(6, d == 1 ? MDP_OUT_BRAKE : MDP_OUT_DRIVE, 1'b1);
      end
      dir = DIR_FWD;
      for (int f = 0; f < 4; f++) begin
         seed = xs(seed);
         flg = 4'h8 >> f;
         cfg.ov_sel = seed[1];
         ck(6, f == 3 ? MDP_OUT_OFF : MDP_OUT_BRAKE, 1'b1);
         flg = '0;
         ck(6, MDP_OUT_DRIVE, 1'b1);
      end
      flg.oc = 1'b1;
      flg.therm = 1'b1;
      ck(6, MDP_OUT_OFF, 1'b1);
      flg = '0;
      dir = DIR_MID;
      sleep = 1'b1;
      ck(6, MDP_OUT_OFF, 1'b1);
      dir = DIR_FWD;
      stall = 1'b1;
      flg.uv = 1'b1;
      ck(LL + 20, MDP_OUT_OFF, 1'b1);
      flg.uv = 1'b0;
      stall = 1'b0;
      sleep = 1'b0;
      ck(6, MDP_OUT_DRIVE, 1'b1);
      // Stall margins allow for half a Hall period plus sync delay
      for (int t = 0; t < 2; t++) begin
         l = t ? LL : LS;
         r = t ? RL : RS;
         cfg.lock_timing = t[0];
         cyc(10);
         stall = 1'b1;
         ck(l - 10, MDP_OUT_DRIVE, 1'b1);
         ck(20, MDP_OUT_BRAKE, 1'b0);
         ck(r - 40, MDP_OUT_BRAKE, 1'b0);
         ck(40, MDP_OUT_DRIVE, 1'b1);
         stall = 1'b0;
         cyc(20);
      end
      cfg.lock_timing = 1'b0;
      stall = 1'b1;
      for (int k = 0; k < 3; k++) begin
         wait_lock(LS + 20);
         case (k)
            0: spd = 1'b1;
            1: kick = 1'b1;
            default: flg.uv = 1'b1;
         endcase
         cyc(1);
         kick = 1'b0;
         cyc(3);
         spd = 1'b0;
         flg.uv = 1'b0;
         ck(6, MDP_OUT_DRIVE, 1'b1);
      end
      stall = 1'b0;
      cyc(20);
      cfg.lock_mode = 1'b1;
      stall = 1'b1;
      ck(LT - 10, MDP_OUT_DRIVE, 1'b1);
      ck(20, MDP_OUT_BRAKE, 1'b0);
      spd = 1'b1;
      kick = 1'b1;
      cyc(1);
      kick = 1'b0;
      cyc(3);
      spd = 1'b0;
      ck(RL + 100, MDP_OUT_BRAKE, 1'b0);
      for (int k = 0; k < 2; k++) begin
         wait_lock(LT + 20);
         if (k == 0) flg.uv = 1'b1;
         else sleep = 1'b1;
         cyc(4);
         flg.uv = 1'b0;
         sleep = 1'b0;
         ck(6, MDP_OUT_DRIVE, 1'b1);
      end
      cfg.lock_timing = 1'b1;
      wait_lock(LS + 20);
      ck(IR / 2, MDP_OUT_BRAKE, 1'b0);
      ck(IR, MDP_OUT_DRIVE, 1'b1);
      stall = 1'b0;
      cyc(2);
      end_of_test();
   end
endmodule // mdp_ctrl_tb
